// ---- dv/host_bus_model.sv ----
// Host processor model on the internal peripheral bus
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
    // Clock
    input  wire logic        ref_clk_i,
    // Bus toward the timer
    output logic      [15:0] bus_addr_o,
    output logic             bus_wr_o,
    output logic             bus_word_o,
    output logic      [15:0] bus_wdata_o,
    output logic             bus_rd_o,
    input  wire logic [7:0]  bus_rdata_i
);
    // Idle bus from time zero
    initial begin
        bus_addr_o  = 16'h0000;
        bus_wr_o    = 1'b0;
        bus_word_o  = 1'b0;
        bus_wdata_o = 16'h0000;
        bus_rd_o    = 1'b0;
    end

    // Word write: password high byte, data low byte, one strobe cycle
    task automatic write_word(input logic [15:0] addr,
                              input logic [15:0] data, input logic word);
        @(negedge ref_clk_i);
        bus_addr_o  = addr;
        bus_wdata_o = data;
        bus_word_o  = word;
        bus_wr_o    = 1'b1;
        @(negedge ref_clk_i);
        // Released bus shows inverted values, never the stale ones
        bus_wr_o    = 1'b0;
        bus_addr_o  = ~addr;
        bus_wdata_o = ~data;
    endtask

    // Byte read; data is taken the cycle after the strobe edge
    task automatic read_byte(input logic [15:0] addr, output logic [7:0] d);
        @(negedge ref_clk_i);
        bus_addr_o = addr;
        bus_word_o = 1'b0;
        bus_rd_o   = 1'b1;
        @(negedge ref_clk_i);
        bus_rd_o   = 1'b0;
        bus_addr_o = ~addr;
        d          = bus_rdata_i;
    endtask
endmodule
`default_nettype wire

// ---- dv/watchdog_interval_timer_tb_top.sv ----
// Self-checking bench for the watchdog/interval timer
`timescale 1ns/1ps
`default_nettype none

module watchdog_interval_timer_tb_top;
    // One table row: a write, then a read with its expected byte
    typedef struct packed {
        logic [15:0] waddr;
        logic        word;
        logic [15:0] wdata;
        logic [15:0] raddr;
        logic [7:0]  exp;
    } row_s;

    logic        ref_clk_i;   // System clock
    logic        arst_n_i;    // External reset pin
    logic        standby_i;   // Standby request
    logic [15:0] bus_addr;    // Bus from host model
    logic        bus_wr;
    logic        bus_word;
    logic [15:0] bus_wdata;
    logic        bus_rd;
    logic [7:0]  bus_rdata;
    logic        irq;         // Interval request
    logic        chip_rst_n;  // Internal chip reset
    logic        pin_out;     // Open drain data
    logic        pin_oe;      // Open drain enable
    logic [7:0]  d;           // Last byte read
    int          failures;
    int          n_tests;
    int          i;
    int          k;
    int          lo;
    int          hi;
    int          divs [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
    // Ordinary register cases, run in order
    row_s        rows [10] = '{
        '{16'hffa8, 1'b1, 16'ha5df, 16'hffa8, 8'h5f},
        '{16'hffa8, 1'b1, 16'hb407, 16'hffa8, 8'h5f},
        '{16'hffa8, 1'b0, 16'ha507, 16'hffa8, 8'h5f},
        '{16'hffa8, 1'b1, 16'ha507, 16'hffa8, 8'h1f},
        '{16'hffa8, 1'b1, 16'ha527, 16'hffa8, 8'h3f},
        '{16'hffa8, 1'b1, 16'h5a3c, 16'hffa9, 8'h3c},
        '{16'hffaa, 1'b1, 16'h5a00, 16'hffab, 8'h3f},
        '{16'hffaa, 1'b1, 16'h5a40, 16'hffab, 8'h7f},
        '{16'hffaa, 1'b1, 16'h3c00, 16'hffab, 8'h7f},
        '{16'hffaa, 1'b0, 16'h5a00, 16'hffad, 8'h00}
    };

    watchdog_interval_timer watchdog_interval_timer_inst (
        .ref_clk_i               (ref_clk_i),
        .arst_n_i                (arst_n_i),
        .standby_i               (standby_i),
        .bus_addr_i              (bus_addr),
        .bus_wr_i                (bus_wr),
        .bus_word_i              (bus_word),
        .bus_wdata_i             (bus_wdata),
        .bus_rd_i                (bus_rd),
        .bus_rdata_o             (bus_rdata),
        .interval_overflow_irq_o (irq),
        .chip_reset_n_o          (chip_rst_n),
        .reset_out_pin_o         (pin_out),
        .reset_out_pin_oe_o      (pin_oe)
    );

    host_bus_model host_bus_model_inst (
        .ref_clk_i   (ref_clk_i),
        .bus_addr_o  (bus_addr),
        .bus_wr_o    (bus_wr),
        .bus_word_o  (bus_word),
        .bus_wdata_o (bus_wdata),
        .bus_rd_o    (bus_rd),
        .bus_rdata_i (bus_rdata)
    );

    // 10 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Compare seen against expected, count both
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Shorthands for the host model
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        host_bus_model_inst.write_word(a, v, 1'b1);
    endtask
    task automatic rd_check(input logic [15:0] a, input logic [7:0] e);
        host_bus_model_inst.read_byte(a, d);
        check($sformatf("read %h", a), {8'h00, d}, {8'h00, e});
    endtask

    // Single exit point
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #10_000_000;
        failures++;
        final_report();
    end

    initial begin
        failures  = 0;
        n_tests   = 0;
        arst_n_i  = 1'b0;
        standby_i = 1'b0;
        repeat (20) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        // Reset values
        check("chip reset", {15'h0, chip_rst_n}, 16'h1);
        check("pin enable", {15'h0, pin_oe}, 16'h0);
        rd_check(16'hffa8, 8'h18);
        rd_check(16'hffa9, 8'h00);
        rd_check(16'hffab, 8'h3f);
        // Table of ordinary register cases
        foreach (rows[r]) begin
            host_bus_model_inst.write_word(rows[r].waddr, rows[r].wdata,
                                           rows[r].word);
            rd_check(rows[r].raddr, rows[r].exp);
        end
        // Every clock select: readback and tick count over 3 periods
        for (k = 0; k < 8; k++) begin
            wr(16'hffa8, {8'ha5, 5'h00, k[2:0]});
            wr(16'hffa8, {8'ha5, 5'h04, k[2:0]});
            repeat (3 * divs[k]) @(negedge ref_clk_i);
            host_bus_model_inst.read_byte(16'hffa9, d);
            check("tick count", {15'h0, d >= 8'h03 && d <= 8'h04},
                  16'h1);
            rd_check(16'hffa8, {5'h07, k[2:0]});
        end
        // Interval overflow from a preloaded count
        wr(16'hffa8, 16'ha520);
        wr(16'hffa8, 16'h5afd);
        for (i = 0; i < 40 && irq !== 1'b1; i++) @(negedge ref_clk_i);
        if (i == 40) begin
            failures++; // Limit ran out
            final_report();
        end
        check("irq raised", {15'h0, irq}, 16'h1);
        wr(16'hffa8, 16'ha520);
        rd_check(16'hffa8, 8'hb8);
        wr(16'hffa8, 16'ha520);
        rd_check(16'hffa8, 8'h38);
        check("irq cleared", {15'h0, irq}, 16'h0);
        wr(16'hffa8, 16'ha500);
        rd_check(16'hffa9, 8'h00);
        // Standby clears bits 7 to 5, keeps the clock select
        wr(16'hffa8, 16'ha527);
        standby_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        rd_check(16'hffa8, 8'h1f);
        standby_i = 1'b0;
        // Watchdog trip with the reset pin output enabled
        lo = 0;
        hi = 0;
        wr(16'hffa8, 16'ha560);
        wr(16'hffa8, 16'h5afe);
        for (i = 0; i < 1000 && !(lo > 0 && chip_rst_n); i++) begin
            @(negedge ref_clk_i);
            lo += int'(chip_rst_n === 1'b0);
            hi += int'(pin_oe === 1'b1);
        end
        if (i == 1000) begin
            failures++; // Limit ran out
            final_report();
        end
        check("reset states", lo[15:0], 16'd518);
        check("pin states", hi[15:0], 16'd132);
        rd_check(16'hffab, 8'hff);
        rd_check(16'hffa8, 8'h18);
        wr(16'hffaa, 16'ha500);
        rd_check(16'hffab, 8'h7f);
        // Pin reset clears the output enable bit that the watchdog reset left set
        arst_n_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        rd_check(16'hffab, 8'h3f);
        final_report();
    end
endmodule
`default_nettype wire

// ---- dv/wdt_checker_sva.sv ----
// Port level assertions for the watchdog/interval timer
`timescale 1ns/1ps
`default_nettype none

module wdt_checker (
    // Clock and reset pin
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    // Standby and bus
    input  wire logic        standby_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic        bus_wr_i,
    input  wire logic        bus_word_i,
    input  wire logic [15:0] bus_wdata_i,
    input  wire logic        bus_rd_i,
    input  wire logic [7:0]  bus_rdata_o,
    // Outputs under watch
    input  wire logic        interval_overflow_irq_o,
    input  wire logic        chip_reset_n_o,
    input  wire logic        reset_out_pin_o,
    input  wire logic        reset_out_pin_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    logic [9:0] low_q;  // Cycles chip reset held low so far
    logic [9:0] oe_q;   // Cycles reset pin pulled low so far

    // Pulse length counters; too long to unroll as repetitions
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_q <= 10'h000;
            oe_q  <= 10'h000;
        end else begin
            low_q <= chip_reset_n_o ? 10'h000 : low_q + 10'h001;
            oe_q  <= reset_out_pin_oe_o ? oe_q + 10'h001 : 10'h000;
        end
    end

    int_reset_len_a: assert property (
        $rose(chip_reset_n_o) |-> low_q == 10'h206)
        else $error("internal reset pulse length wrong");
    pin_pulse_len_a: assert property (
        $fell(reset_out_pin_oe_o) |-> oe_q == 10'h084)
        else $error("reset pin pulse length wrong");
    pin_in_reset_a: assert property (
        reset_out_pin_oe_o |-> !chip_reset_n_o)
        else $error("reset pin pulled outside chip reset");
    pin_data_low_a: assert property (reset_out_pin_o == 1'b0)
        else $error("open drain data not low");
    fixed_ones_a: assert property (
        bus_rd_i && bus_addr_i == 16'hffa8 |=> bus_rdata_o[4:3] == 2'h3)
        else $error("control bits 4 and 3 not read as one");
    reserved_ones_a: assert property (
        bus_rd_i && bus_addr_i == 16'hffab |=> bus_rdata_o[5:0] == 6'h3f)
        else $error("reset register low bits not read as one");
    rdata_hold_a: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
        else $error("read data changed without a read");
    hold_no_irq_a: assert property (
        !chip_reset_n_o ##1 !chip_reset_n_o |-> !interval_overflow_irq_o)
        else $error("interval request during watchdog reset");
    standby_irq_a: assert property (
        standby_i [*3] |=> !interval_overflow_irq_o)
        else $error("interval request kept in standby");
endmodule

bind watchdog_interval_timer wdt_checker wdt_checker_inst (
    .ref_clk_i, .arst_n_i, .standby_i, .bus_addr_i, .bus_wr_i,
    .bus_word_i, .bus_wdata_i, .bus_rd_i, .bus_rdata_o,
    .interval_overflow_irq_o, .chip_reset_n_o, .reset_out_pin_o,
    .reset_out_pin_oe_o
);
`default_nettype wire

// ---- logic/watchdog_interval_timer.sv ----
// Watchdog/interval timer with password protected registers
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module watchdog_interval_timer (
    // Clock and external reset pin (asynchronous, active low)
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    // Software standby request, same clock domain
    input  wire logic        standby_i,
    // Internal peripheral bus
    input  wire logic [15:0] bus_addr_i,
    input  wire logic        bus_wr_i,
    input  wire logic        bus_word_i,
    input  wire logic [15:0] bus_wdata_i,
    input  wire logic        bus_rd_i,
    output logic      [7:0]  bus_rdata_o,
    // Interval interrupt request
    output logic             interval_overflow_irq_o,
    // Internal chip reset, active low
    output logic             chip_reset_n_o,
    // Open drain external reset output
    output logic             reset_out_pin_o,
    output logic             reset_out_pin_oe_o
);

    // Register state
    logic               overflow_flag_q;     // Timer control bit 7
    logic               mode_select_bit_q;   // 1 = watchdog
    logic               timer_enable_bit_q;  // 1 = counting
    wdt_pkg::cks_t      clock_select_q;      // Rate code
    logic [7:0]         watchdog_counter_q;  // Counter
    logic               watchdog_reset_flag_q;
    logic               reset_output_enable_q;

    // Read-then-write arming for the two clearable flags
    logic               ovf_armed_q;
    logic               watchdog_reset_flag_armed_q;

    // Sequencer
    wdt_pkg::wdt_state_e state_q;
    wdt_pkg::wdt_state_e state_d;

    // Decoded strobes
    logic               word_wr;       // Legal word write
    logic               timer_wr;      // Write at shared timer address
    logic               cnt_wr;        // Counter password matched
    logic               tcs_wr;        // Control password matched
    logic               rcs_wr;        // Write at reset register address
    logic               watchdog_reset_flag_clr_wr;   // Flag clear word
    logic               reset_output_enable_wr;      // Output enable load word
    logic [7:0]         wr_hi;         // Password byte
    logic [7:0]         wr_lo;         // Data byte

    // Counting
    logic               tick;          // Selected prescaled tick
    logic               count_inc;     // Counter advances this cycle
    logic               overflow;      // Counter wraps this cycle
    logic               wd_trip;       // Overflow in watchdog mode
    logic               hold_regs;     // Timer registers forced to reset

    // Reset pulse timers
    logic               int_rst_active;
    logic               ext_rst_active;

    // Read view of the two control/status registers
    logic [7:0]         tcs_view;
    logic [7:0]         rcs_view;

    // Byte writes carry no password, so only word writes are decoded
    assign word_wr  = bus_wr_i && bus_word_i;
    assign wr_hi    = bus_wdata_i[15:8];
    assign wr_lo    = bus_wdata_i[7:0];
    assign timer_wr = word_wr && (bus_addr_i == `WDT_WADDR_TIMER);
    assign rcs_wr   = word_wr && (bus_addr_i == `WDT_WADDR_RESET);

    // Any other password byte falls through to no write at all
    assign cnt_wr      = timer_wr && (wr_hi == `WDT_PW_COUNTER);
    assign tcs_wr      = timer_wr && (wr_hi == `WDT_PW_CONTROL);
    assign watchdog_reset_flag_clr_wr = rcs_wr && (wr_hi == `WDT_PW_RST_CLEAR)
                         && (wr_lo == `WDT_RST_CLEAR_DATA);
    assign reset_output_enable_wr    = rcs_wr && (wr_hi == `WDT_PW_RST_OE);

    // Prescaler for the counter clock
    wdt_prescaler u_prescaler (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .cks_i     (clock_select_q),
        .tick_o    (tick)
    );

    // Timer registers other than the clock select are held at reset values outside normal running
    assign hold_regs = (state_q != wdt_pkg::ST_RUN);

    // A tick landing on a counter write is dropped; the write wins
    assign count_inc = timer_enable_bit_q && tick && !cnt_wr
                       && !hold_regs;
    assign overflow  = count_inc
                       && (watchdog_counter_q == 8'hff);
    assign wd_trip   = overflow && mode_select_bit_q;

    // Internal reset pulse length
    wdt_pulse_timer #(
        .LEN (10'(`WDT_INT_RST_STATES))
    ) u_int_rst (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .start_i   (wd_trip),
        .active_o  (int_rst_active)
    );

    // External reset pulse, only when output is enabled
    wdt_pulse_timer #(
        .LEN (10'(`WDT_EXT_RST_STATES))
    ) u_ext_rst (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .start_i   (wd_trip && reset_output_enable_q),
        .active_o  (ext_rst_active)
    );

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            wdt_pkg::ST_RUN: begin
                if (wd_trip) begin
                    // Watchdog reset takes the chip down
                    state_d = wdt_pkg::ST_HOLD;
                end else if (standby_i) begin
                    state_d = wdt_pkg::ST_STANDBY;
                end
            end
            wdt_pkg::ST_HOLD: begin
                // Leave once the internal reset pulse has ended
                if (!int_rst_active) begin
                    state_d = wdt_pkg::ST_RUN;
                end
            end
            wdt_pkg::ST_STANDBY: begin
                if (!standby_i) begin
                    state_d = wdt_pkg::ST_RUN;
                end
            end
            default: begin
                // Unused code recovers to normal running
                state_d = wdt_pkg::ST_RUN;
            end
        endcase
    end

    // Sequencer register
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= wdt_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Counter: zero on reset, hold or enable low; write beats tick
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            watchdog_counter_q <= `WDT_CNT_RESET;
        end else if (hold_regs || !timer_enable_bit_q) begin
            watchdog_counter_q <= `WDT_CNT_RESET;
        end else if (cnt_wr) begin
            watchdog_counter_q <= wr_lo;
        end else if (count_inc) begin
            watchdog_counter_q <= watchdog_counter_q + 8'h01;
        end
    end

    // Mode and enable: cleared by reset, hold and standby
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_select_bit_q  <= 1'b0;
            timer_enable_bit_q <= 1'b0;
        end else if (hold_regs) begin
            mode_select_bit_q  <= 1'b0;
            timer_enable_bit_q <= 1'b0;
        end else if (tcs_wr) begin
            mode_select_bit_q  <= wr_lo[`WDT_TCS_MODE_BIT];
            timer_enable_bit_q <= wr_lo[`WDT_TCS_TME_BIT];
        end
    end

    // Clock select: kept through standby, cleared by any reset
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clock_select_q <= `WDT_CKS_RESET;
        end else if (state_q == wdt_pkg::ST_HOLD) begin
            clock_select_q <= `WDT_CKS_RESET;
        end else if (tcs_wr && !hold_regs) begin
            // Software should stop the counter before changing rate
            clock_select_q <= wr_lo[`WDT_TCS_CKS_MSB:0];
        end
    end

    // Overflow flag arming: a read that sees it at one
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ovf_armed_q <= 1'b0;
        end else if (hold_regs) begin
            ovf_armed_q <= 1'b0;
        end else if (bus_rd_i && (bus_addr_i == `WDT_RADDR_TCS)
                     && overflow_flag_q) begin
            ovf_armed_q <= 1'b1;
        end else if (tcs_wr) begin
            // Any control write uses up the arming
            ovf_armed_q <= 1'b0;
        end
    end

    // Overflow flag: a new overflow beats a clear in the same cycle
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            overflow_flag_q <= 1'b0;
        end else if (overflow) begin
            overflow_flag_q <= 1'b1;
        end else if (hold_regs) begin
            overflow_flag_q <= 1'b0;
        end else if (tcs_wr && ovf_armed_q
                     && !wr_lo[`WDT_TCS_OVF_BIT]) begin
            // Writing one is ignored; only a zero clears
            overflow_flag_q <= 1'b0;
        end
    end

    // Reset flag arming; survives the watchdog's own reset
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            watchdog_reset_flag_armed_q <= 1'b0;
        end else if (bus_rd_i && (bus_addr_i == `WDT_RADDR_RCS)
                     && watchdog_reset_flag_q) begin
            watchdog_reset_flag_armed_q <= 1'b1;
        end else if (rcs_wr) begin
            watchdog_reset_flag_armed_q <= 1'b0;
        end
    end

    // Reset flag: set by watchdog trip, cleared only by armed A5/00
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            watchdog_reset_flag_q <= 1'b0;
        end else if (wd_trip) begin
            watchdog_reset_flag_q <= 1'b1;
        end else if (watchdog_reset_flag_clr_wr && watchdog_reset_flag_armed_q) begin
            watchdog_reset_flag_q <= 1'b0;
        end
    end

    // Output enable: only the pin reset initializes it
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reset_output_enable_q <= 1'b0;
        end else if (reset_output_enable_wr) begin
            reset_output_enable_q <= wr_lo[`WDT_RCS_OE_BIT];
        end
    end

    // Read views; fixed bits always read as one
    assign tcs_view = {overflow_flag_q, mode_select_bit_q,
                       timer_enable_bit_q, `WDT_TCS_FIXED_ONES,
                       clock_select_q};
    assign rcs_view = {watchdog_reset_flag_q, reset_output_enable_q,
                       `WDT_RCS_FIXED_ONES};

    // Byte read port, data one cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_rdata_o <= `WDT_UNMAPPED_READ;
        end else if (bus_rd_i) begin
            unique case (bus_addr_i)
                `WDT_RADDR_TCS: bus_rdata_o <= tcs_view;
                `WDT_RADDR_CNT: bus_rdata_o <= watchdog_counter_q;
                `WDT_RADDR_RCS: bus_rdata_o <= rcs_view;
                default:        bus_rdata_o <= `WDT_UNMAPPED_READ;
            endcase
        end
    end

    // Interval request follows the flag while in interval mode
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            interval_overflow_irq_o <= 1'b0;
        end else begin
            interval_overflow_irq_o <= overflow_flag_q
                                       && !mode_select_bit_q;
        end
    end

    // Reset outputs registered once more, lagging the timers by one
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chip_reset_n_o     <= 1'b1;
            reset_out_pin_oe_o <= 1'b0;
        end else begin
            chip_reset_n_o     <= !int_rst_active;
            reset_out_pin_oe_o <= ext_rst_active;
        end
    end

    // Open drain: only ever pulls low, enable does the driving
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reset_out_pin_o <= 1'b0;
        end else begin
            reset_out_pin_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- logic/wdt_defs.svh ----
// Constants for the watchdog/interval timer: addresses, fields, resets, timing
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// Write addresses (word writes only)
`define WDT_WADDR_TIMER      16'hffa8
`define WDT_WADDR_RESET      16'hffaa

// Read addresses (byte reads)
`define WDT_RADDR_TCS        16'hffa8
`define WDT_RADDR_CNT        16'hffa9
`define WDT_RADDR_RCS        16'hffab

// Passwords carried in the upper byte of a write word
`define WDT_PW_COUNTER       8'h5a
`define WDT_PW_CONTROL       8'ha5
`define WDT_PW_RST_CLEAR     8'ha5
`define WDT_PW_RST_OE        8'h5a
`define WDT_RST_CLEAR_DATA   8'h00

// Timer control/status field positions
`define WDT_TCS_OVF_BIT      7
`define WDT_TCS_MODE_BIT     6
`define WDT_TCS_TME_BIT      5
`define WDT_TCS_CKS_MSB      2
`define WDT_TCS_FIXED_ONES   2'h3

// Reset control/status field positions
`define WDT_RCS_WATCHDOG_RESET_FLAG_BIT     7
`define WDT_RCS_OE_BIT       6
`define WDT_RCS_FIXED_ONES   6'h3f

// Reset values
`define WDT_TCS_RESET        8'h18
`define WDT_CNT_RESET        8'h00
`define WDT_RCS_RESET        8'h3f
`define WDT_CKS_RESET        3'h0
`define WDT_UNMAPPED_READ    8'h00

// Prescaler width: the slowest tap divides by 4096
`define WDT_PRESC_W          12

// Reset pulse lengths in system clock states (one state is one clock)
`define WDT_INT_RST_STATES   518
`define WDT_EXT_RST_STATES   132
`define WDT_RST_CNT_W        10

`endif

// ---- logic/wdt_pkg.sv ----
// Types shared by the watchdog/interval timer files
`default_nettype none
package wdt_pkg;

    // Sequencer states, Gray coded along run -> hold and run -> standby
    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,  // Normal operation
        ST_HOLD    = 2'b01,  // Internal watchdog reset in progress
        ST_STANDBY = 2'b10   // Software standby
    } wdt_state_e;

    // Counter clock select codes
    typedef logic [2:0] cks_t;

endpackage
`default_nettype wire

// ---- logic/wdt_prescaler.sv ----
// Free running prescaler giving one-cycle ticks at eight selectable rates
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_prescaler (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             arst_n_i,
    // Rate select
    input  wire wdt_pkg::cks_t    cks_i,
    // Selected tick
    output logic                  tick_o
);

    logic [`WDT_PRESC_W-1:0] div_q;    // Free running divider
    logic [`WDT_PRESC_W-1:0] mask;     // Low bits that must be all ones

    // Divider never stops, so a rate change takes effect at once
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q <= 12'h000;
        end else begin
            div_q <= div_q + 12'h001;
        end
    end

    // Divide by 2,32,64,128,256,512,2048,4096
    always_comb begin
        unique case (cks_i)
            3'h0: mask = 12'h001;
            3'h1: mask = 12'h01f;
            3'h2: mask = 12'h03f;
            3'h3: mask = 12'h07f;
            3'h4: mask = 12'h0ff;
            3'h5: mask = 12'h1ff;
            3'h6: mask = 12'h7ff;
            3'h7: mask = 12'hfff;
        endcase
    end

    // One tick each time the selected low bits roll over
    assign tick_o = ((div_q & mask) == mask);

endmodule
`default_nettype wire

// ---- logic/wdt_pulse_timer.sv ----
// Fixed length pulse timer, started by a one-cycle request
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_pulse_timer #(
    parameter logic [`WDT_RST_CNT_W-1:0] LEN = 10'h001  // Pulse cycles
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic arst_n_i,
    // Start request
    input  wire logic start_i,
    // Pulse, high for LEN cycles after start
    output logic      active_o
);

    logic [`WDT_RST_CNT_W-1:0] left_q;  // Cycles left after this one

    // A start during a running pulse is ignored, not restarted
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            active_o <= 1'b0;
            left_q   <= 10'h000;
        end else if (start_i && !active_o) begin
            active_o <= 1'b1;
            left_q   <= LEN - 10'h001;
        end else if (active_o) begin
            if (left_q == 10'h000) begin
                active_o <= 1'b0;
            end else begin
                left_q <= left_q - 10'h001;
            end
        end
    end

endmodule
`default_nettype wire
